// ==== core/adc_cal_pkg.sv ====
// Types shared by the calibration and reset sequencer.
// Assumes the constants header sits beside it on the include path.
package adc_cal_pkg;
  `include "adc_cal_regs.svh"

  typedef enum logic [1:0] {
    ST_POR = 2'b00,
    ST_RESET = 2'b01,
    ST_CAL = 2'b10,
    ST_RUN = 2'b11
  } seq_state_t;

  typedef struct packed {
    logic [11:0] code;
    logic over_range;
  } sample_out_t;

  typedef struct packed {
    logic valid;
    logic [1:0] ratio;
  } div_override_t;
endpackage

// ==== core/adc_cal_regs.svh ====
// Constants for the calibration and reset sequencer: timing, codes, reset values.
// Assumes inclusion by its bare name from the package and the design file.
`ifndef ADC_CAL_REGS_SVH
`define ADC_CAL_REGS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SYS_CLK_HZ 10000000
`define CAL_NOMINAL_MS 200
`define CAL_MAX_MS 550
`define CAL_NOMINAL_CYCLES ((`CAL_NOMINAL_MS * `SYS_CLK_HZ) / 1000)
`define DLL_RELOCK_US 52
`define DLL_RELOCK_CYCLES ((`DLL_RELOCK_US * `SYS_CLK_HZ) / 1000000)
`define PIPE_HALF_STEPS 15
`define CORE_PIPE_SAMPLES 6

// ----------------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------------
`define CODE_FULL_SCALE 12'hfff
`define DIV_SEL_LOW 2'h0
`define DIV_SEL_FLOAT 2'h1
`define DIV_SEL_HIGH 2'h2
`define RATIO_RESET 3'h1

`endif

// ==== core/adc_calibration_reset_sequencer.sv ====
// Calibration, reset and clock-divider sequencer of a pipelined converter core.
// Assumes sys_clk is the input sample clock; pins come from outside and are synchronised.
`timescale 1ns/1ps
`include "adc_cal_regs.svh"

module adc_calibration_reset_sequencer #(
  parameter int CAL_CYCLES = `CAL_NOMINAL_CYCLES,
  parameter int RELOCK_CYCLES = `DLL_RELOCK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Supply detectors and reset pin
  input wire logic avdd_good,
  input wire logic dvdd_good,
  input wire logic cal_reset_n_in,
  output logic cal_reset_n_out,
  output logic cal_reset_n_oe,
  // Divider control
  input wire logic [1:0] clock_divide_select,
  input wire adc_cal_pkg::div_override_t div_override,
  input wire logic phase_slip,
  // Converter core
  input wire logic [11:0] core_code,
  // Outputs
  output adc_cal_pkg::sample_out_t sample_out,
  output logic output_clock_pair,
  output logic cal_busy,
  output logic dll_locked
);
  import adc_cal_pkg::*;

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  logic [1:0] sup_meta_r, sup_sync_r;
  logic rstn_meta_r, rstn_sync_r, rstn_prev_r;
  logic [1:0] sel_meta_r, sel_sync_r;
  logic slip_meta_r, slip_sync_r;

  // Supply flags: both must read good before the detector lets go of the line.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sup_meta_r <= 2'h0;
      sup_sync_r <= 2'h0;
    end else begin
      sup_meta_r <= {avdd_good, dvdd_good};
      sup_sync_r <= sup_meta_r;
    end
  end

  // Reset line, with one stage more so that its rising edge can be seen.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rstn_meta_r <= 1'b0;
      rstn_sync_r <= 1'b0;
      rstn_prev_r <= 1'b0;
    end else begin
      rstn_meta_r <= cal_reset_n_in;
      rstn_sync_r <= rstn_meta_r;
      rstn_prev_r <= rstn_sync_r;
    end
  end

  // The select pin starts at the floating code, which is divide by one.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sel_meta_r <= `DIV_SEL_FLOAT;
      sel_sync_r <= `DIV_SEL_FLOAT;
    end else begin
      sel_meta_r <= clock_divide_select;
      sel_sync_r <= sel_meta_r;
    end
  end

  // Phase slip request.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      slip_meta_r <= 1'b0;
      slip_sync_r <= 1'b0;
    end else begin
      slip_meta_r <= phase_slip;
      slip_sync_r <= slip_meta_r;
    end
  end

  wire supplies_ok = &sup_sync_r;
  wire reset_rise = rstn_sync_r & ~rstn_prev_r;

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------
  seq_state_t state_r;
  logic [31:0] cal_cnt_r;

  // The reset line is open drain: the detector only ever pulls it low.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cal_reset_n_out <= 1'b0;
      cal_reset_n_oe <= 1'b1;
    end else begin
      cal_reset_n_out <= 1'b0;
      cal_reset_n_oe <= ~supplies_ok;
    end
  end

  // Losing either supply drops the sequencer back to power-on, whatever it was doing.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_POR;
      cal_cnt_r <= 32'h0;
    end else begin
      unique case (state_r)
        ST_POR: begin
          if (supplies_ok) begin
            state_r <= ST_RESET;
          end
        end
        ST_RESET: begin
          cal_cnt_r <= 32'h0;
          if (reset_rise) begin
            state_r <= ST_CAL;
          end
        end
        ST_CAL: begin
          if (!rstn_sync_r) begin
            state_r <= ST_RESET;
          end else if (cal_cnt_r >= 32'(CAL_CYCLES - 1)) begin
            state_r <= ST_RUN;
          end else begin
            cal_cnt_r <= cal_cnt_r + 32'h1;
          end
        end
        ST_RUN: begin
          if (!rstn_sync_r) begin
            state_r <= ST_RESET;
          end
        end
      endcase
      if (!supplies_ok) begin
        state_r <= ST_POR;
      end
    end
  end

  wire in_cal = (state_r != ST_RUN);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cal_busy <= 1'b1;
    end else begin
      cal_busy <= in_cal;
    end
  end

  // ----------------------------------------------------------------------------
  // Divider, phase slip and DLL relock
  // ----------------------------------------------------------------------------
  function automatic logic [2:0] ratio_of(input logic [1:0] sel);
    unique case (sel)
      `DIV_SEL_LOW: ratio_of = 3'h2;
      `DIV_SEL_HIGH: ratio_of = 3'h4;
      default: ratio_of = 3'h1;
    endcase
  endfunction

  logic [2:0] ratio_r, ratio_prev_r;
  logic [1:0] div_cnt_r;
  logic slip_prev_r;
  logic sample_tick_r;
  logic [31:0] lock_cnt_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ratio_r <= `RATIO_RESET;
    end else if (div_override.valid) begin
      ratio_r <= ratio_of(div_override.ratio);
    end else begin
      ratio_r <= ratio_of(sel_sync_r);
    end
  end

  // At divide by two only, a phase slip swallows one input edge so converters can be brought into step.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_cnt_r <= 2'h0;
      slip_prev_r <= 1'b0;
      sample_tick_r <= 1'b0;
    end else begin
      slip_prev_r <= slip_sync_r;
      if (ratio_r == 3'h2 && slip_sync_r && !slip_prev_r) begin
        sample_tick_r <= 1'b0;
      end else if (div_cnt_r >= 2'(ratio_r - 3'h1)) begin
        div_cnt_r <= 2'h0;
        sample_tick_r <= 1'b1;
      end else begin
        div_cnt_r <= div_cnt_r + 2'h1;
        sample_tick_r <= 1'b0;
      end
    end
  end

  // Relock time scales with sample period, so it grows with the ratio.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ratio_prev_r <= `RATIO_RESET;
      lock_cnt_r <= 32'h0;
      dll_locked <= 1'b0;
    end else begin
      ratio_prev_r <= ratio_r;
      if (ratio_r != ratio_prev_r) begin
        lock_cnt_r <= 32'(RELOCK_CYCLES) * 32'(ratio_r);
        dll_locked <= 1'b0;
      end else if (lock_cnt_r != 32'h0) begin
        lock_cnt_r <= lock_cnt_r - 32'h1;
        dll_locked <= 1'b0;
      end else begin
        dll_locked <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Pipeline and output clock
  // ----------------------------------------------------------------------------
  // Half-step delay line: fifteen half sample steps give seven and a half samples.
  logic [11:0] pipe_r [0:`PIPE_HALF_STEPS-1];
  logic phase_r;

  // A tick at divide by one already spans a whole sample, so it is worth two half steps.
  function automatic logic whole_sample_tick(input logic [2:0] ratio);
    whole_sample_tick = (ratio == 3'h1);
  endfunction

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase_r <= 1'b0;
      for (int i = 0; i < `PIPE_HALF_STEPS; i++) begin
        pipe_r[i] <= 12'h000;
      end
    end else if (sample_tick_r || phase_r) begin
      phase_r <= sample_tick_r && !whole_sample_tick(ratio_r);
      pipe_r[0] <= core_code;
      if (whole_sample_tick(ratio_r)) begin
        pipe_r[1] <= core_code;
        for (int i = 2; i < `PIPE_HALF_STEPS; i++) begin
          pipe_r[i] <= pipe_r[i-2];
        end
      end else begin
        for (int i = 1; i < `PIPE_HALF_STEPS; i++) begin
          pipe_r[i] <= pipe_r[i-1];
        end
      end
    end
  end

  // Output clock: one pulse per sample, silent while the reset line is low.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      output_clock_pair <= 1'b0;
    end else if (!rstn_sync_r) begin
      output_clock_pair <= 1'b0;
    end else if (sample_tick_r) begin
      output_clock_pair <= 1'b1;
    end else begin
      output_clock_pair <= 1'b0;
    end
  end

  // Over-range follows the synchronised line as well as the state, so it rises a cycle sooner.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sample_out <= '{code: 12'h000, over_range: 1'b1};
    end else begin
      if (in_cal || !rstn_sync_r) begin
        sample_out.over_range <= 1'b1;
      end else if (sample_tick_r) begin
        sample_out.over_range <= (pipe_r[`PIPE_HALF_STEPS-1] == `CODE_FULL_SCALE);
      end
      if (sample_tick_r) begin
        sample_out.code <= pipe_r[`PIPE_HALF_STEPS-1];
      end
    end
  end

endmodule // adc_calibration_reset_sequencer

// ==== testbench/adc_cal_checker_sva.sv ====
// Checker of the calibration sequencer: reset line, over-range, output clock.
// Assumes binding to the sequencer top with the same parameters.
`timescale 1ns/1ps
module adc_cal_checker
  import adc_cal_pkg::*;
#(
  parameter int CAL_CYCLES = 50,
  parameter int RELOCK_CYCLES = 8
) (
  // Inputs of the sequencer
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic avdd_good,
  input wire logic dvdd_good,
  input wire logic cal_reset_n_in,
  input wire logic [1:0] clock_divide_select,
  input wire adc_cal_pkg::div_override_t div_override,
  input wire logic phase_slip,
  input wire logic [11:0] core_code,
  // Outputs of the sequencer
  input wire logic cal_reset_n_out,
  input wire logic cal_reset_n_oe,
  input wire adc_cal_pkg::sample_out_t sample_out,
  input wire logic output_clock_pair,
  input wire logic cal_busy,
  input wire logic dll_locked
);
  localparam int CMAX = CAL_CYCLES + 8;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Four samples cover the two-flop synchroniser and the register behind it.
  sequence line_held_low;
    !cal_reset_n_in [*4];
  endsequence
  sequence cal_launch;
    $rose(cal_reset_n_in) && avdd_good && dvdd_good;
  endsequence
  chk_por_hold_low: assert property ((!avdd_good || !dvdd_good) [*5] |-> cal_reset_n_oe && !cal_reset_n_out)
    else $error("line not pulled while supplies low");
  chk_por_line_free: assert property ((avdd_good && dvdd_good) [*5] |-> !cal_reset_n_oe)
    else $error("line still pulled with supplies good");
  chk_oclk_quiet: assert property (line_held_low |-> !output_clock_pair)
    else $error("output clock runs while line low");
  chk_or_in_reset: assert property (line_held_low |-> sample_out.over_range)
    else $error("over-range low while line low");
  chk_or_while_cal: assert property (cal_busy |-> sample_out.over_range)
    else $error("over-range low during calibration");
  chk_cal_time: assert property (cal_launch |-> ##[CAL_CYCLES:CMAX] $fell(cal_busy))
    else $error("calibration length wrong");
  chk_full_scale: assert property (sample_out.code == 12'hfff && !cal_busy |-> sample_out.over_range)
    else $error("over-range low at full scale");
  chk_relock_min: assert property ($rose(dll_locked) |-> $past(dll_locked, 6) == 1'b0)
    else $error("relock too short");
endmodule // adc_cal_checker

// ==== testbench/adc_calibration_reset_sequencer_test.sv ====
// Self-checking bench of the calibration sequencer.
// Assumes short counts: 50 calibration cycles, relock unit of 8.
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("FAIL %0t %s", $time, m); end end
module adc_calibration_reset_sequencer_test;
  import adc_cal_pkg::*;
  localparam int CAL = 50;
  logic sys_clk, rst, avdd_good, dvdd_good, cal_reset_n_in, cal_reset_n_out, cal_reset_n_oe;
  logic phase_slip, output_clock_pair, cal_busy, dll_locked, cmd_reset;
  logic [1:0] clock_divide_select;
  logic [11:0] core_code;
  div_override_t div_override;
  sample_out_t sample_out;
  int n_fail, n_compared;
  adc_calibration_reset_sequencer #(.CAL_CYCLES(CAL), .RELOCK_CYCLES(8)) i_adc_calibration_reset_sequencer (
    .sys_clk, .rst, .avdd_good, .dvdd_good, .cal_reset_n_in, .cal_reset_n_out, .cal_reset_n_oe,
    .clock_divide_select, .div_override, .phase_slip, .core_code, .sample_out, .output_clock_pair,
    .cal_busy, .dll_locked);
  sys_ctrl_model i_sys_ctrl_model (.sys_clk, .dev_pull_low(cal_reset_n_oe && !cal_reset_n_out),
    .cmd_reset, .line_level(cal_reset_n_in));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_cal(output int n);
    n = 0;
    while (cal_busy !== 1'b0 && n < 1000) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic ticks(input int n, output int k);
    k = 0;
    repeat (n) begin
      cyc(1);
      if (output_clock_pair === 1'b1) k++;
    end
  endtask
  task automatic test_power_up;
    int n;
    `CHK(cal_reset_n_oe, 1'b1, "line free")
    `CHK(sample_out.over_range, 1'b1, "or low")
    `CHK(output_clock_pair, 1'b0, "oclk runs")
    avdd_good = 1'b1;
    cyc(8);
    `CHK(cal_reset_n_oe, 1'b1, "freed on one supply")
    dvdd_good = 1'b1;
    cyc(6);
    `CHK(cal_reset_n_oe, 1'b0, "line held")
    cmd_reset = 1'b0;
    wait_cal(n);
    `CHK(n >= CAL && n <= CAL + 8, 1'b1, "cal time")
    `CHK(sample_out.over_range, 1'b0, "end not seen")
    $display("test_power_up done");
  endtask
  task automatic test_data;
    int n;
    cyc(40);
    core_code = 12'h5a3;
    n = 0;
    while (sample_out.code !== 12'h5a3 && n < 40) begin
      cyc(1);
      n++;
    end
    // Seven and a half samples at divide by one, rounded up, plus the capture edge.
    `CHK(n >= 8 && n <= 9, 1'b1, "latency")
    `CHK(sample_out.over_range, 1'b0, "or after cal")
    core_code = 12'hfff;
    cyc(30);
    `CHK(sample_out, {12'hfff, 1'b1}, "full scale")
    $display("test_data done");
  endtask
  task automatic test_recal;
    int n, k;
    cmd_reset = 1'b1;
    cyc(5);
    `CHK({sample_out.over_range, output_clock_pair, cal_busy}, 3'h5, "in reset")
    cmd_reset = 1'b0;
    ticks(8, k);
    `CHK(k > 0, 1'b1, "oclk stopped")
    wait_cal(n);
    `CHK(n + 8 >= CAL && n + 8 <= CAL + 8, 1'b1, "recal time")
    $display("test_recal done");
  endtask
  task automatic test_divider;
    int k;
    int div[3] = '{2, 1, 4};
    for (int s = 0; s < 3; s++) begin
      clock_divide_select = s[1:0];
      cyc(60);
      ticks(24, k);
      `CHK(k, 24 / div[s], "pin ratio")
    end
    clock_divide_select = 2'h1;
    cyc(60);
    div_override = '{valid: 1'b1, ratio: 2'h2};
    cyc(4);
    `CHK(dll_locked, 1'b0, "no relock")
    cyc(60);
    `CHK(dll_locked, 1'b1, "no lock")
    ticks(24, k);
    `CHK(k, 6, "override")
    div_override = '{valid: 1'b1, ratio: 2'h0};
    cyc(60);
    // Align to an output clock pulse so the swallowed edge always costs one pulse in the window.
    k = 0;
    while (output_clock_pair !== 1'b1 && k < 8) begin
      cyc(1);
      k++;
    end
    phase_slip = 1'b1;
    ticks(24, k);
    `CHK(k, 11, "phase slip")
    phase_slip = 1'b0;
    $display("test_divider done");
  endtask
  task automatic final_report;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {rst, cmd_reset, avdd_good, dvdd_good, phase_slip} = 5'h18;
    clock_divide_select = 2'h1;
    div_override = '0;
    core_code = 12'h400;
    n_fail = 0;
    n_compared = 0;
    cyc(6);
    rst = 1'b0;
    cyc(2);
    test_power_up();
    test_data();
    test_recal();
    test_divider();
    final_report();
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_fail++;
    final_report();
  end
endmodule // adc_calibration_reset_sequencer_test
bind adc_calibration_reset_sequencer adc_cal_checker #(.CAL_CYCLES(CAL_CYCLES), .RELOCK_CYCLES(RELOCK_CYCLES))
  i_adc_cal_checker (.sys_clk, .rst, .avdd_good, .dvdd_good, .cal_reset_n_in, .clock_divide_select,
  .div_override, .phase_slip, .core_code, .cal_reset_n_out, .cal_reset_n_oe, .sample_out,
  .output_clock_pair, .cal_busy, .dll_locked);

// ==== testbench/sys_ctrl_model.sv ====
// System controller model: open-drain pull on the reset line plus its pull-up.
// Assumes the device drives the line only low, qualified by its enable.
`timescale 1ns/1ps
module sys_ctrl_model (
  // Clock
  input wire logic sys_clk,
  // Reset line
  input wire logic dev_pull_low,
  input wire logic cmd_reset,
  output logic line_level
);
  logic hold_low_r;
  always_ff @(posedge sys_clk) begin
    hold_low_r <= cmd_reset;
  end
  // Wired-AND: the pull-up wins only when neither party pulls.
  assign line_level = !(hold_low_r || dev_pull_low);
endmodule // sys_ctrl_model
